/* File: logic/oap_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module oap_regs (
  input wire logic clock, // System clock, 100 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic power_down_n_pin, // Power-down pin, low powers down
  input wire logic power_control_bit, // Power-control bit, zero powers down
  input wire logic reg_wr, // Control-port write strobe
  input wire logic reg_rd, // Control-port read strobe
  input wire logic [7:0] reg_addr, // Control-port register address
  input wire logic [7:0] reg_wdata, // Control-port write data
  output logic [7:0] reg_rdata, // Read data, valid after read
  input wire logic left_mod_valid, // Left modulator word strobe
  input wire logic [oap_pkg::SAMPLE_W-1:0] left_mod_data, // Left modulator word
  input wire logic right_mod_valid, // Right modulator word strobe
  input wire logic [oap_pkg::SAMPLE_W-1:0] right_mod_data, // Right modulator word
  output logic left_out_valid, // Left output sample strobe
  output logic [oap_pkg::SAMPLE_W-1:0] left_out_data, // Left output sample
  output logic right_out_valid, // Right output sample strobe
  output logic [oap_pkg::SAMPLE_W-1:0] right_out_data, // Right output sample
  output logic [7:0] left_volume_code, // Left output volume code
  output logic [7:0] right_volume_code // Right output volume code
);
  import oap_pkg::*;

  typedef struct packed {
    logic pdn_meta;
    logic pdn_sync;
    logic [7:0] vol_l;
    logic [7:0] vol_r;
    logic [7:0] rdata;
  } oap_top_state_t;

  oap_top_state_t s_q, s_d;

  logic [NUM_CH-1:0] ch_mod_valid;
  logic [NUM_CH-1:0][SAMPLE_W-1:0] ch_mod_data;
  logic [NUM_CH-1:0] ch_clear;
  logic [NUM_CH-1:0] ch_out_valid;
  logic [NUM_CH-1:0][SAMPLE_W-1:0] ch_out_data;
  logic [NUM_CH-1:0][PEAK_W-1:0] ch_peak;
  logic powered_down;

  assign ch_mod_valid = {right_mod_valid, left_mod_valid};
  assign ch_mod_data = {right_mod_data, left_mod_data};

  // Peak clear: power-down, power-control bit, or high-byte read
  assign powered_down = !s_q.pdn_sync || !power_control_bit;
  assign ch_clear[CH_LEFT] = powered_down || (reg_rd && reg_addr == ADDR_LEFT_PEAK_HI);
  assign ch_clear[CH_RIGHT] = powered_down || (reg_rd && reg_addr == ADDR_RIGHT_PEAK_HI);

  // One independent capture per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    oap_channel u_ch (
      .clock(clock),
      .resetn(resetn),
      .mod_valid(ch_mod_valid[c]),
      .mod_data(ch_mod_data[c]),
      .peak_clear(ch_clear[c]),
      .out_valid(ch_out_valid[c]),
      .out_data(ch_out_data[c]),
      .peak(ch_peak[c])
    );
  end

  // Pin sync, volume registers and read mux
  always_comb begin
    s_d = s_q;
    s_d.pdn_meta = power_down_n_pin;
    s_d.pdn_sync = s_q.pdn_meta;
    // Writes land on the volume outputs next cycle; power-control bit has no say
    if (reg_wr && reg_addr == ADDR_LEFT_VOL) begin
      s_d.vol_l = reg_wdata;
    end else if (reg_wr && reg_addr == ADDR_RIGHT_VOL) begin
      s_d.vol_r = reg_wdata;
    end
    // Pin low overrides any write
    if (!s_q.pdn_sync) begin
      s_d.vol_l = VOL_RESET;
      s_d.vol_r = VOL_RESET;
    end
    // Read data; the low byte is the host's first read of a pair
    if (reg_rd) begin
      if (reg_addr == ADDR_LEFT_VOL) begin
        s_d.rdata = s_q.vol_l;
      end else if (reg_addr == ADDR_RIGHT_VOL) begin
        s_d.rdata = s_q.vol_r;
      end else if (reg_addr == ADDR_LEFT_PEAK_LO) begin
        s_d.rdata = ch_peak[CH_LEFT][7:0];
      end else if (reg_addr == ADDR_LEFT_PEAK_HI) begin
        s_d.rdata = ch_peak[CH_LEFT][15:8];
      end else if (reg_addr == ADDR_RIGHT_PEAK_LO) begin
        s_d.rdata = ch_peak[CH_RIGHT][7:0];
      end else if (reg_addr == ADDR_RIGHT_PEAK_HI) begin
        s_d.rdata = ch_peak[CH_RIGHT][15:8];
      end else begin
        s_d.rdata = READ_ZERO;
      end
    end
  end

  // State register; pin sync resets to powered down
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q.pdn_meta <= 1'b0;
      s_q.pdn_sync <= 1'b0;
      s_q.vol_l <= VOL_RESET;
      s_q.vol_r <= VOL_RESET;
      s_q.rdata <= READ_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign left_volume_code = s_q.vol_l;
  assign right_volume_code = s_q.vol_r;
  assign left_out_valid = ch_out_valid[CH_LEFT];
  assign left_out_data = ch_out_data[CH_LEFT];
  assign right_out_valid = ch_out_valid[CH_RIGHT];
  assign right_out_data = ch_out_data[CH_RIGHT];
endmodule
`default_nettype wire

/* File: shared/oap_pkg.sv */
`default_nettype none
package oap_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_LEFT_VOL = 8'h08;
  localparam logic [7:0] ADDR_RIGHT_VOL = 8'h09;
  localparam logic [7:0] ADDR_LEFT_PEAK_LO = 8'h0a;
  localparam logic [7:0] ADDR_LEFT_PEAK_HI = 8'h0b;
  localparam logic [7:0] ADDR_RIGHT_PEAK_LO = 8'h0c;
  localparam logic [7:0] ADDR_RIGHT_PEAK_HI = 8'h0d;
  // Reset and limit values
  localparam logic [7:0] VOL_RESET = 8'h7f;
  localparam logic [7:0] VOL_MAX = 8'h90;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Datapath shape
  localparam int SAMPLE_W = 24;
  localparam int PEAK_W = 16;
  localparam int DEC_RATIO = 64;
  localparam int HPF_SHIFT = 10;
  localparam int NUM_CH = 2;
  // Channel indices
  localparam int CH_LEFT = 0;
  localparam int CH_RIGHT = 1;
endpackage
`default_nettype wire

/* File: logic/oap_channel.sv */
`timescale 1ns/100ps
`default_nettype none
module oap_channel #(
  parameter int SW = oap_pkg::SAMPLE_W,
  parameter int PW = oap_pkg::PEAK_W,
  parameter int DEC = oap_pkg::DEC_RATIO,
  parameter int HSH = oap_pkg::HPF_SHIFT
) (
  input wire logic clock, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic mod_valid, // Modulator word strobe
  input wire logic [SW-1:0] mod_data, // Modulator word, two's complement
  input wire logic peak_clear, // Clear held peak
  output logic out_valid, // Output sample strobe
  output logic [SW-1:0] out_data, // Output sample, two's complement
  output logic [PW-1:0] peak // Held peak magnitude
);
  import oap_pkg::*;

  localparam int LD = $clog2(DEC);
  localparam int AW = SW + LD;
  localparam logic [LD-1:0] CNT_LAST = LD'(DEC - 1);
  localparam logic signed [SW-1:0] POS_MAX = {1'b0, {(SW-1){1'b1}}};
  localparam logic signed [SW-1:0] NEG_MIN = {1'b1, {(SW-1){1'b0}}};

  if (PW > SW - 1 || DEC < 2 || (1 << LD) != DEC || HSH < 1 || HSH >= SW) begin : g_bad
    $error("oap_channel: unsupported parameters");
  end

  typedef struct packed {
    logic [LD-1:0] cnt;
    logic [AW-1:0] acc;
    logic [SW-1:0] x_prev;
    logic [SW-1:0] y;
    logic valid;
    logic [PW-1:0] peak;
  } oap_ch_state_t;

  oap_ch_state_t s_q, s_d;

  logic [AW-1:0] acc_sum;
  logic signed [SW-1:0] dec_word;
  logic signed [SW+1:0] hp;
  logic signed [SW-1:0] y_new;
  logic [SW-1:0] mag;
  logic [PW-1:0] cand;
  logic [PW-1:0] held;

  // Decimation, DC removal and peak capture
  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    acc_sum = s_q.acc + {{LD{mod_data[SW-1]}}, mod_data};
    dec_word = acc_sum[AW-1:LD];
    // Signed operands keep the shift arithmetic and the sum two's complement
    hp = $signed({{2{dec_word[SW-1]}}, dec_word}) - $signed({{2{s_q.x_prev[SW-1]}}, s_q.x_prev})
      + $signed({{2{s_q.y[SW-1]}}, s_q.y}) - ($signed({{2{s_q.y[SW-1]}}, s_q.y}) >>> HSH);
    // Saturate the filter output to the sample width; signed compares
    if (hp > $signed({2'b00, POS_MAX})) begin
      y_new = POS_MAX;
    end else if (hp < $signed({2'b11, NEG_MIN})) begin
      y_new = NEG_MIN;
    end else begin
      y_new = hp[SW-1:0];
    end
    // Magnitude; the most negative word is clipped to full scale
    if (y_new == NEG_MIN) begin
      mag = POS_MAX;
    end else if (y_new[SW-1]) begin
      mag = -y_new;
    end else begin
      mag = y_new;
    end
    cand = mag[SW-2 -: PW];
    // Clear applies first so a same-cycle sample is never lost
    held = peak_clear ? '0 : s_q.peak;
    s_d.peak = held;
    if (mod_valid) begin
      // One word per modulator tick, DEC ticks per output sample
      if (s_q.cnt == CNT_LAST) begin
        s_d.cnt = '0;
        s_d.acc = '0;
        s_d.x_prev = dec_word;
        s_d.y = y_new;
        s_d.valid = 1'b1;
        if (cand > held) begin
          s_d.peak = cand;
        end
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
        s_d.acc = acc_sum;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_valid = s_q.valid;
  assign out_data = s_q.y;
  assign peak = s_q.peak;
endmodule
`default_nettype wire

/* File: dv/oap_props.sv */
`timescale 1ns/100ps
`default_nettype none
module oap_props (
  input wire logic clock, // Clock
  input wire logic resetn, // Reset, low
  input wire logic power_down_n_pin, // Pin
  input wire logic power_control_bit, // Bit
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic left_out_valid, // Left strobe
  input wire logic right_out_valid, // Right strobe
  input wire logic [7:0] left_volume_code, // Left code
  input wire logic [7:0] right_volume_code // Right code
);
  import oap_pkg::*;
  logic [3:0] hist_q;
  logic pin_up;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Pin history, covers the synchroniser delay
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) hist_q <= 4'h0;
    else hist_q <= {hist_q[2:0], power_down_n_pin};
  end
  assign pin_up = (&hist_q) && power_down_n_pin;
  sequence s_pc_down;
    !power_control_bit ##1 (reg_rd && reg_addr >= ADDR_LEFT_PEAK_LO && reg_addr <= ADDR_RIGHT_PEAK_HI
      && !left_out_valid && !right_out_valid);
  endsequence
  a_left_write: assert property (reg_wr && reg_addr == ADDR_LEFT_VOL && pin_up
    |=> left_volume_code == $past(reg_wdata)) else $error("left code not written");
  a_right_write: assert property (reg_wr && reg_addr == ADDR_RIGHT_VOL && pin_up
    |=> right_volume_code == $past(reg_wdata)) else $error("right code not written");
  a_pin_forces: assert property (hist_q == 4'h0 && !power_down_n_pin
    |=> left_volume_code == VOL_RESET && right_volume_code == VOL_RESET) else $error("codes not forced");
  a_vol_hold: assert property (!reg_wr && pin_up
    |=> $stable(left_volume_code) && $stable(right_volume_code)) else $error("code changed");
  a_read_left: assert property (reg_rd && !reg_wr && reg_addr == ADDR_LEFT_VOL
    |=> reg_rdata == $past(left_volume_code)) else $error("left code read wrong");
  a_unmapped_read: assert property (reg_rd && (reg_addr < ADDR_LEFT_VOL || reg_addr > ADDR_RIGHT_PEAK_HI)
    |=> reg_rdata == READ_ZERO) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_peak_clear: assert property (s_pc_down |=> reg_rdata == READ_ZERO) else $error("peak not cleared");
  a_left_pulse: assert property (left_out_valid |=> !left_out_valid) else $error("strobe too long");
endmodule
bind oap_regs oap_props u_props (.clock, .resetn, .power_down_n_pin, .power_control_bit, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .left_out_valid, .right_out_valid, .left_volume_code, .right_volume_code);
`default_nettype wire

/* File: dv/oap_mod_src.sv */
`timescale 1ns/100ps
`default_nettype none
module oap_mod_src (
  input wire logic clock, // Clock
  input wire logic start, // Begin a burst
  input wire logic [oap_pkg::SAMPLE_W-1:0] left_word, // Left word
  input wire logic [oap_pkg::SAMPLE_W-1:0] right_word, // Right word
  output logic mod_valid, // Word strobe
  output logic [oap_pkg::SAMPLE_W-1:0] left_data, // Left data
  output logic [oap_pkg::SAMPLE_W-1:0] right_data // Right data
);
  import oap_pkg::*;
  int cnt = 0;
  initial begin
    mod_valid = 1'b0;
    left_data = '0;
    right_data = '0;
  end
  // One output sample worth of words, idle data toggles
  always @(negedge clock) begin
    if (start && cnt == 0) cnt = DEC_RATIO;
    mod_valid <= cnt != 0;
    left_data <= cnt != 0 ? left_word : ~left_data;
    right_data <= cnt != 0 ? right_word : ~right_data;
    if (cnt != 0) cnt = cnt - 1;
  end
endmodule
`default_nettype wire

/* File: dv/tb_oap_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_oap_regs;
  import oap_pkg::*;
  logic clock = 0, resetn = 0, power_down_n_pin = 1, power_control_bit = 1, start = 0;
  logic reg_wr = 0, reg_rd = 0, mod_valid, left_out_valid, right_out_valid;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, left_volume_code, right_volume_code;
  logic [SAMPLE_W-1:0] left_word = 0, right_word = 0, left_mod_data, right_mod_data, left_out_data, right_out_data;
  int num_errors = 0, compares = 0, left_pulses = 0, right_pulses = 0;
  always #5 clock = ~clock;
  // Output strobe counters, looked at mid-cycle
  always @(negedge clock) begin
    if (left_out_valid) left_pulses++;
    if (right_out_valid) right_pulses++;
  end
  oap_mod_src src (.clock(clock), .start(start), .left_word(left_word), .right_word(right_word),
    .mod_valid(mod_valid), .left_data(left_mod_data), .right_data(right_mod_data));
  oap_regs dut (.clock(clock), .resetn(resetn), .power_down_n_pin(power_down_n_pin),
    .power_control_bit(power_control_bit), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .left_mod_valid(mod_valid), .left_mod_data(left_mod_data),
    .right_mod_valid(mod_valid), .right_mod_data(right_mod_data), .left_out_valid(left_out_valid),
    .left_out_data(left_out_data), .right_out_valid(right_out_valid), .right_out_data(right_out_data),
    .left_volume_code(left_volume_code), .right_volume_code(right_volume_code));
  task chk(input logic [SAMPLE_W-1:0] got, input logic [SAMPLE_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clock) reg_wr = 0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clock) reg_rd = 0;
    chk(reg_rdata, e);
  endtask
  task burst(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
    {left_word, right_word} = {l, r};
    @(negedge clock) start <= 1'b1;
    @(negedge clock) start <= 1'b0;
    repeat (70) @(negedge clock);
  endtask
  task test_done;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge clock);
    resetn = 1;
    repeat (4) @(negedge clock);
    rd_chk(8'h08, 8'h7f);
    rd_chk(8'h09, 8'h7f);
    for (logic [7:0] a = 8'h0a; a <= 8'h0d; a++) rd_chk(a, 8'h00);
    rd_chk(8'h0e, 8'h00);
    $display("test reset done");
    wr_reg(8'h08, 8'h90);
    wr_reg(8'h09, 8'h12);
    wr_reg(8'h0a, 8'h55);
    chk(left_volume_code, 8'h90);
    chk(right_volume_code, 8'h12);
    rd_chk(8'h08, 8'h90);
    rd_chk(8'h0a, 8'h00);
    $display("test volume done");
    burst(24'hedcb80, 24'h000000);
    chk(left_out_data, 24'hedcb80);
    chk(right_out_data, 24'h000000);
    rd_chk(8'h0a, 8'h69);
    rd_chk(8'h0b, 8'h24);
    rd_chk(8'h0a, 8'h00);
    rd_chk(8'h0c, 8'h00);
    rd_chk(8'h0d, 8'h00);
    burst(24'h000000, 24'h800000);
    chk(right_out_data, 24'h800000);
    chk(SAMPLE_W'(left_pulses), 24'h000002);
    chk(SAMPLE_W'(right_pulses), 24'h000002);
    rd_chk(8'h0c, 8'hff);
    rd_chk(8'h0d, 8'hff);
    $display("test peak done");
    power_control_bit = 0;
    rd_chk(8'h0a, 8'h00);
    rd_chk(8'h0b, 8'h00);
    chk(left_volume_code, 8'h90);
    power_control_bit = 1;
    power_down_n_pin = 0;
    repeat (4) @(negedge clock);
    wr_reg(8'h09, 8'h33);
    chk(left_volume_code, 8'h7f);
    chk(right_volume_code, 8'h7f);
    power_down_n_pin = 1;
    $display("test power done");
    test_done;
  end
endmodule
`default_nettype wire
